// *** core/mcu_addr_regs.vh ***
`ifndef MCU_ADDR_REGS_VH
`define MCU_ADDR_REGS_VH
// operation codes presented on op_code
`define OP_NONE 4'h0
`define OP_RAM_INDIRECT 4'h1
`define OP_RAM_DIRECT 4'h2
`define OP_WINDOW_LOAD 4'h3
`define OP_WINDOW_SWAP 4'h4
`define OP_LONG_JUMP 4'h5
`define OP_LONG_BRANCH 4'h6
`define OP_LONG_CALL 4'h7
`define OP_PAGE_JUMP 4'h8
`define OP_ZERO_CALL 4'h9
`define OP_TABLE_JUMP 4'hA
`define OP_PATTERN 4'hB
// memory register window base
`define WINDOW_BASE 10'h040
// pattern word control bits
`define PAT_ACC_BIT 8
`define PAT_PORT_BIT 9
// reset values
`define PC_RESET 14'h0000
`define RAM_ADDR_RESET 10'h000
`endif

// *** core/mcu_address_generation.v ***
// What this block does
// RULE1 - indirect RAM address from three pointers
// RULE2 - direct access takes address from second word
// RULE3 - sixteen-word window via load/swap only
// RULE4 - long jumps load all fourteen bits
// RULE5 - sixty-four pages of 256 words
// RULE6 - page jump replaces low eight bits
// RULE7 - page jump at page end uses next page
// RULE8 - zero call loads six low bits
// RULE9 - zero call clears upper eight bits
// RULE10 - table target from immediate, A, B
// RULE11 - pattern bit 8 loads A/B pair
// RULE12 - pattern bit 9 loads port latches
// RULE13 - both bits update both destinations
// RULE14 - pattern fetch advances PC normally
// RULE15 - page, row, column order in address
`timescale 1ns/1ps
`default_nettype none
`include "mcu_addr_regs.vh"
module mcu_address_generation (
  input wire clk,
  input wire sys_rst,
  input wire op_valid,
  input wire [3:0] op_code,
  input wire [13:0] imm_data,
  input wire [1:0] page_ptr,
  input wire [3:0] row_ptr,
  input wire [3:0] col_ptr,
  input wire [9:0] second_word,
  input wire [3:0] acc_in,
  input wire [3:0] b_in,
  input wire [9:0] rom_data,
  input wire rom_data_valid,
  output reg [13:0] program_counter,
  output reg [9:0] ram_addr_reg,
  output reg ram_valid_reg,
  output reg [13:0] rom_addr_reg,
  output reg rom_req_reg,
  output reg [3:0] acc_out_reg,
  output reg [3:0] b_out_reg,
  output reg acc_we_reg,
  output reg [3:0] port1_reg,
  output reg [3:0] port2_reg,
  output reg port_we_reg
);
  // table address: immediate, accumulator, B
  function [13:0] table_addr;
    input [3:0] imm;
    input [3:0] a;
    input [3:0] b;
    begin
      table_addr = {imm, 2'h0, a, b}; // RULE10
    end
  endfunction

  // page-local target: page of the incremented pc
  function [13:0] page_target;
    input [13:0] pc_plus;
    input [7:0] offset;
    begin
      page_target = {pc_plus[13:8], offset}; // RULE6 RULE7
    end
  endfunction

  // zero-page target: upper eight bits cleared
  function [13:0] zero_target;
    input [5:0] offset;
    begin
      zero_target = {8'h00, offset}; // RULE8 RULE9
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  wire [9:0] ram_addr_c;
  wire ram_valid_c;
  // the mux sees no operation while op_valid is low
  wire [3:0] mux_op = op_valid ? op_code : `OP_NONE;

  // ram address formation
  ram_addr_mux u_ram_mux (
    .op_code(mux_op),
    .page_ptr(page_ptr),
    .row_ptr(row_ptr),
    .col_ptr(col_ptr),
    .second_word(second_word),
    .window_index(imm_data[3:0]),
    .ram_addr(ram_addr_c),
    .ram_valid(ram_valid_c)
  );

  ////////////////////////////////////////////////////////////////
  // incremented pc: already crossed page at 256n+255
  wire [13:0] pc_inc = program_counter + 14'h0001; // RULE5

  // next values of the sequencing state
  reg [13:0] pc_next;
  reg rom_req_next;
  reg [13:0] rom_addr_next;
  reg pend_reg;
  reg pend_next;

  // next values of the pattern destinations
  reg [3:0] acc_out_next;
  reg [3:0] b_out_next;
  reg acc_we_next;
  reg [3:0] port1_next;
  reg [3:0] port2_next;
  reg port_we_next;

  // decoded pattern op and an accepted returning word
  wire pat_op = op_valid && (op_code == `OP_PATTERN);
  wire pat_take = rom_data_valid && pend_reg;

  // next program counter selection
  always @* begin
    pc_next = pc_inc;
    // pc counts by one unless a jump op replaces it
    if (op_valid) begin
      case (op_code)
        `OP_LONG_JUMP, `OP_LONG_BRANCH, `OP_LONG_CALL: begin
          pc_next = imm_data; // RULE4
        end
        `OP_PAGE_JUMP: begin
          pc_next = page_target(pc_inc, imm_data[7:0]); // RULE6 RULE7
        end
        `OP_ZERO_CALL: begin
          pc_next = zero_target(imm_data[5:0]); // RULE8 RULE9
        end
        `OP_TABLE_JUMP: begin
          pc_next = table_addr(imm_data[3:0], acc_in, b_in); // RULE10
        end
        `OP_PATTERN: begin
          pc_next = pc_inc; // RULE14
        end
        default: begin
          pc_next = pc_inc;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // pattern fetch request and its table address
  always @* begin
    rom_req_next = pat_op;
    rom_addr_next = rom_addr_reg;
    if (pat_op) begin
      rom_addr_next = table_addr(imm_data[3:0], acc_in, b_in); // RULE11
    end
  end

  ////////////////////////////////////////////////////////////////
  // pending fetch: a new request wins over a returning word
  always @* begin
    pend_next = pend_reg;
    if (rom_data_valid) begin
      pend_next = 1'b0; // unsolicited words are dropped
    end
    if (pat_op) begin
      pend_next = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // control bits of an accepted pattern word
  wire pat_to_acc = pat_take && rom_data[`PAT_ACC_BIT];
  wire pat_to_port = pat_take && rom_data[`PAT_PORT_BIT];

  // pattern word steering: both bits may be set together
  always @* begin
    acc_out_next = acc_out_reg;
    b_out_next = b_out_reg;
    acc_we_next = 1'b0;
    port1_next = port1_reg;
    port2_next = port2_reg;
    port_we_next = 1'b0;
    if (pat_to_acc) begin
      acc_out_next = rom_data[3:0]; // RULE11 RULE13
      b_out_next = rom_data[7:4];
      acc_we_next = 1'b1;
    end
    if (pat_to_port) begin
      port1_next = rom_data[3:0]; // RULE12 RULE13
      port2_next = rom_data[7:4];
      port_we_next = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // sequencing state: pc, ram address, fetch request
  always @(posedge clk) begin
    if (sys_rst) begin
      program_counter <= `PC_RESET;
      ram_addr_reg <= `RAM_ADDR_RESET;
      ram_valid_reg <= 1'b0;
      rom_addr_reg <= 14'h0000;
      rom_req_reg <= 1'b0;
      pend_reg <= 1'b0;
    end else begin
      program_counter <= pc_next;
      ram_addr_reg <= ram_addr_c;
      ram_valid_reg <= ram_valid_c;
      rom_addr_reg <= rom_addr_next;
      rom_req_reg <= rom_req_next;
      pend_reg <= pend_next;
    end
  end

  // pattern destinations: accumulator pair and port latches
  always @(posedge clk) begin
    if (sys_rst) begin
      acc_out_reg <= 4'h0;
      b_out_reg <= 4'h0;
      acc_we_reg <= 1'b0;
      port1_reg <= 4'h0;
      port2_reg <= 4'h0;
      port_we_reg <= 1'b0;
    end else begin
      acc_out_reg <= acc_out_next;
      b_out_reg <= b_out_next;
      acc_we_reg <= acc_we_next;
      port1_reg <= port1_next;
      port2_reg <= port2_next;
      port_we_reg <= port_we_next;
    end
  end
endmodule // mcu_address_generation
`default_nettype wire

// *** core/ram_addr_mux.v ***
`timescale 1ns/1ps
`default_nettype none
`include "mcu_addr_regs.vh"
module ram_addr_mux (
  input wire [3:0] op_code,
  input wire [1:0] page_ptr,
  input wire [3:0] row_ptr,
  input wire [3:0] col_ptr,
  input wire [9:0] second_word,
  input wire [3:0] window_index,
  output reg [9:0] ram_addr,
  output reg ram_valid
);
  // address source selection
  always @* begin
    ram_addr = `RAM_ADDR_RESET;
    ram_valid = 1'b0;
    case (op_code)
      `OP_RAM_INDIRECT: begin
        ram_addr = {page_ptr, row_ptr, col_ptr}; // RULE1 RULE15
        ram_valid = 1'b1;
      end
      `OP_RAM_DIRECT: begin
        ram_addr = second_word; // RULE2
        ram_valid = 1'b1;
      end
      `OP_WINDOW_LOAD, `OP_WINDOW_SWAP: begin
        ram_addr = `WINDOW_BASE | {6'h00, window_index}; // RULE3
        ram_valid = 1'b1;
      end
      default: begin
        ram_addr = `RAM_ADDR_RESET;
        ram_valid = 1'b0;
      end
    endcase
  end
endmodule // ram_addr_mux
`default_nettype wire

// *** dv/mcu_addr_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module mcu_addr_checker (input wire clk, input wire sys_rst, input wire op_valid,
  input wire [3:0] op_code, input wire [13:0] imm_data, input wire [1:0] page_ptr,
  input wire [3:0] row_ptr, input wire [3:0] col_ptr, input wire [9:0] second_word,
  input wire [3:0] acc_in, input wire [3:0] b_in, input wire [9:0] rom_data,
  input wire rom_data_valid, input wire [13:0] program_counter, input wire [9:0] ram_addr_reg,
  input wire ram_valid_reg, input wire rom_req_reg, input wire acc_we_reg, input wire port_we_reg);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // each op ties its result to the previous edge's inputs
  a_ind_addr: assert property (op_valid && op_code == 4'h1 |=> ram_valid_reg &&
    ram_addr_reg == {$past(page_ptr), $past(row_ptr), $past(col_ptr)}) else $error("ind");
  a_dir_addr: assert property (op_valid && op_code == 4'h2 |=>
    ram_valid_reg && ram_addr_reg == $past(second_word)) else $error("dir");
  a_win_addr: assert property (op_valid && op_code inside {4'h3, 4'h4} |=>
    ram_addr_reg == (10'h040 | $past(imm_data[3:0]))) else $error("win");
  a_long_jump: assert property (op_valid && op_code inside {4'h5, 4'h6, 4'h7} |=>
    program_counter == $past(imm_data)) else $error("long");
  a_page_jump: assert property (op_valid && op_code == 4'h8 |=> program_counter ==
    ((($past(program_counter) + 14'h1) & 14'h3F00) | $past(imm_data[7:0]))) else $error("page");
  a_zero_call: assert property (op_valid && op_code == 4'h9 |=>
    program_counter == $past(imm_data[5:0])) else $error("zero");
  a_table_jump: assert property (op_valid && op_code == 4'hA |=> program_counter ==
    {$past(imm_data[3:0]), 2'h0, $past(acc_in), $past(b_in)}) else $error("table");
  a_pat_pc: assert property (op_valid && op_code == 4'hB |=> rom_req_reg &&
    program_counter == $past(program_counter) + 14'h1) else $error("pat pc");
  a_pat_write: assert property (rom_req_reg && rom_data_valid |=>
    {port_we_reg, acc_we_reg} == $past(rom_data[9:8])) else $error("pat we");
  a_no_stray: assert property (!rom_data_valid |=>
    !acc_we_reg && !port_we_reg) else $error("stray we");
endmodule // mcu_addr_checker
bind mcu_address_generation mcu_addr_checker chk_u (.*);
`default_nettype wire

// *** dv/mcu_address_generation_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module mcu_address_generation_tb;
  reg clk = 1'b0, sys_rst = 1'b1, op_valid = 1'b0, rom_data_valid = 1'b0;
  reg [3:0] op_code = 4'h0, acc_in = 4'h0, b_in = 4'h0, row_ptr = 4'h0, col_ptr = 4'h0;
  reg [1:0] page_ptr = 2'h0;
  reg [13:0] imm_data = 14'h0000, p = 14'h0000;
  reg [9:0] second_word = 10'h000, rom_data = 10'h000, ea;
  wire [13:0] program_counter, rom_addr_reg;
  wire [9:0] ram_addr_reg;
  wire [3:0] acc_out_reg, b_out_reg, port1_reg, port2_reg;
  wire ram_valid_reg, rom_req_reg, acc_we_reg, port_we_reg;
  integer fails = 0, checked = 0, i, s;
  mcu_address_generation dut_u (.*);
  always #50 clk = ~clk;
  ////////////////////////////////////////////////////////////
  // next pc for an op taken at pc q
  function [13:0] nx(input [3:0] o, input [13:0] q);
    case (o)
      4'h5, 4'h6, 4'h7: nx = imm_data;
      4'h8: nx = ((q + 14'h1) & 14'h3F00) | imm_data[7:0];
      4'h9: nx = imm_data[5:0];
      4'hA: nx = {imm_data[3:0], 2'h0, acc_in, b_in};
      default: nx = q + 14'h1;
    endcase
  endfunction
  task chk(input string n, input [13:0] e, input [13:0] g);
    checked = checked + 1;
    if (g !== e) begin
      fails = fails + 1;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task test_done;
    $display("fails %0d checked %0d", fails, checked);
    if (fails == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // random ops, first a long jump to a page's last word, then a page jump from it
  initial begin
    s = $urandom(82025);
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    for (i = 0; i < 300; i = i + 1) begin
      op_code = $urandom % 12;
      imm_data = $urandom;
      {page_ptr, row_ptr, col_ptr} = $urandom;
      {second_word, acc_in, b_in} = $urandom;
      if (i < 2) {op_code, imm_data} = {i ? 4'h8 : 4'h5, 14'h12FF};
      op_valid = 1'b1;
      @(negedge clk);
      p = nx(op_code, p);
      chk("pc", p, program_counter);
      chk("ramv", op_code inside {[4'h1:4'h4]}, ram_valid_reg);
      chk("req", op_code == 4'hB, rom_req_reg);
      ea = op_code == 4'h1 ? {page_ptr, row_ptr, col_ptr} :
        op_code == 4'h2 ? second_word : 10'h040 | imm_data[3:0];
      if (op_code inside {[4'h1:4'h4]}) chk("ram", ea, ram_addr_reg);
      if (op_code == 4'hB) begin
        chk("rom", {imm_data[3:0], 2'h0, acc_in, b_in}, rom_addr_reg);
        op_valid = 1'b0;
        rom_data = $urandom;
        rom_data_valid = 1'b1;
        @(negedge clk) rom_data_valid = 1'b0;
        p = p + 14'h1;
        chk("pc", p, program_counter);
        chk("we", rom_data[9:8], {port_we_reg, acc_we_reg});
        if (rom_data[8]) chk("acc", rom_data[7:0], {b_out_reg, acc_out_reg});
        if (rom_data[9]) chk("port", rom_data[7:0], {port2_reg, port1_reg});
      end
    end
    test_done;
  end
  // watchdog against a hang
  initial begin
    #200000;
    fails = fails + 1;
    test_done;
  end
endmodule // mcu_address_generation_tb
`default_nettype wire
